/* core/aip_top.sv */
// Interrupt collection and prioritisation for the analog die: pending
// status, source masks and the vector register on the core's register port.
// Assumes source flags are levels held by their own blocks until serviced.
`timescale 1ns/1ps

// Summary of operation
// [RULE1] Calibration request shows in low status bit 5
// [RULE2] Lifetime counter event shows in low bit 4
// [RULE3] Measurement complete shows in low bit 3
// [RULE4] Serial receive, transmit, error in bits 2..0
// [RULE5] Low status read-only, bits 7 and 6 zero
// [RULE6] Vector holds highest-priority pending source code
// [RULE7] Vector reads zero when nothing pending
// [RULE8] Codes 1..3: undervoltage, high temp, LIN overtemp
// [RULE9] Codes 4..7: timer channels 0..3, lower first
// [RULE10] Code 8 overflow; 9..11 serial error, transmit, receive
// [RULE11] Codes 12..14: measurement, lifetime, calibration lowest
// [RULE12] High mask bit layout; 1 disables source
// [RULE13] Low mask bit layout; 1 disables source
// [RULE14] Registers at page 0x02 or 0x03 offsets
// [RULE15] High status layout matches high mask layout
// [RULE16] Measurement flag from current or voltage completion
// [RULE17] Masked sources skipped; request only when unmasked pending
// [RULE18] Both masks reset to zero
module aip_top
	import aip_pkg::*;
(
	input  wire logic                 i_core_clk,  // Core clock, 25 MHz
	input  wire logic                 i_rst_n,     // Async reset, active low
	input  wire aip_pkg::aip_src_t    i_src,       // Source flags, levels
	input  wire aip_pkg::aip_bus_req_t i_bus,      // Register port request
	output logic [aip_pkg::DATA_W-1:0] o_rdata,    // Read data, registered
	output logic                      o_rd_valid,  // Read data valid pulse
	output logic                      o_irq        // Interrupt request
);

	import aip_pkg::*;

	logic [HIGH_W-1:0] status_high;
	logic [LOW_W-1:0]  status_low;
	logic [HIGH_W-1:0] mask_high;
	logic [LOW_W-1:0]  mask_low;
	aip_vector_t       vector;

	wire [HIGH_W-1:0] next_status_high = aip_pack_high(i_src);  // [RULE15]
	wire [LOW_W-1:0]  next_status_low  = aip_pack_low(i_src);   // [RULE16]

	// Both pages alias the same registers; blocking only matters to the core
	wire       page_block = (i_bus.addr[15:8] == BASE_BLOCKING_PAGE);
	wire       page_nonbl = (i_bus.addr[15:8] == BASE_NONBLOCK_PAGE);
	wire       page_hit   = page_block || page_nonbl;              // [RULE14]
	wire [7:0] offset     = i_bus.addr[7:0];

	wire sel_status_high = page_hit && (offset == OFS_STATUS_HIGH);
	wire sel_status_low  = page_hit && (offset == OFS_STATUS_LOW);
	wire sel_vector      = page_hit && (offset == OFS_VECTOR);
	wire sel_reserved    = page_hit && (offset == OFS_RESERVED);
	wire sel_mask_high   = page_hit && (offset == OFS_MASK_HIGH);
	wire sel_mask_low    = page_hit && (offset == OFS_MASK_LOW);

	// Status and vector have no write path, so writes there are dropped
	wire wr_mask_high = i_bus.wr && sel_mask_high;  // [RULE12]
	wire wr_mask_low  = i_bus.wr && sel_mask_low;   // [RULE13]

	wire [DATA_W-1:0] rd_status_low = {2'h0, status_low};          // [RULE5]
	wire [DATA_W-1:0] rd_vector     = {4'h0, vector};              // [RULE7]
	wire [DATA_W-1:0] rd_mask_low   = {2'h0, mask_low};

	wire [DATA_W-1:0] read_mux =
		sel_status_high ? status_high   :
		sel_status_low  ? rd_status_low :
		sel_vector      ? rd_vector     :
		sel_mask_high   ? mask_high     :
		sel_mask_low    ? rd_mask_low   :
		8'h00;

	// Priority order equals the register layout: high byte first, then low
	wire [SRC_N-1:0] pend_set = {status_low, status_high};
	wire [SRC_N-1:0] mask_set = {mask_low, mask_high};

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			status_high <= 8'h00;
			status_low  <= 6'h00;
		end
		else
		begin
			status_high <= next_status_high;  // [RULE15]
			status_low  <= next_status_low;   // [RULE1] [RULE2] [RULE3] [RULE4]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rdata    <= 8'h00;
			o_rd_valid <= 1'b0;
		end
		else
		begin
			o_rd_valid <= i_bus.rd;
			if (i_bus.rd)
				o_rdata <= read_mux;  // [RULE14]
		end
	end

	aip_mask_regs #(
		.HW (HIGH_W),
		.LW (LOW_W)
	) u_masks (
		.i_core_clk  (i_core_clk),
		.i_rst_n     (i_rst_n),
		.i_wr_high   (wr_mask_high),
		.i_wr_low    (wr_mask_low),
		.i_wdata     (i_bus.wdata),
		.o_mask_high (mask_high),
		.o_mask_low  (mask_low)
	);

	aip_prio_enc #(
		.N (SRC_N)
	) u_prio (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_pending  (pend_set),
		.i_mask     (mask_set),
		.o_vector   (vector),
		.o_irq      (o_irq)
	);

	// Helper terms read only by the checks below
	wire [SRC_N-1:0] live_set = pend_set & ~mask_set;
	wire             none_live = (live_set == '0);
	wire [LOW_W-1:0] wr_data_low = i_bus.wdata[LOW_W-1:0];

	property p_status_cal;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_src.calibration_request_flag |=> status_low[LO_CAL_POS];
	endproperty
	a_status_cal: assert property (p_status_cal)  // [RULE1]
		else $error("calibration request not shown in low status bit 5");

	property p_status_lifetime;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!i_src.lifetime_counter_flag |=> !status_low[LO_LIFETIME_POS];
	endproperty
	a_status_lifetime: assert property (p_status_lifetime)  // [RULE2]
		else $error("lifetime status bit set with no event");

	property p_status_meas;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_src.current_done || i_src.voltage_done) |=> status_low[LO_MEAS_POS];
	endproperty
	a_status_meas: assert property (p_status_meas)  // [RULE3]
		else $error("measurement completion not shown in low bit 3");

	property p_status_serial;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		1'b1 |=> status_low[2:0] == {$past(i_src.serial_receive_flag),
			$past(i_src.serial_transmit_flag), $past(i_src.serial_error_flag)};
	endproperty
	a_status_serial: assert property (p_status_serial)  // [RULE4]
		else $error("serial status bits out of place");

	sequence s_read_low;
		i_bus.rd && sel_status_low;
	endsequence
	property p_read_low;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_read_low |=> o_rd_valid && (o_rdata[7:6] == 2'h0)
			&& (o_rdata[5:0] == $past(status_low));
	endproperty
	a_read_low: assert property (p_read_low)  // [RULE5]
		else $error("low status read wrong or top bits not zero");

	property p_vector_follows;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		1'b1 |=> vector == aip_first_code($past(live_set));
	endproperty
	a_vector_follows: assert property (p_vector_follows)  // [RULE6]
		else $error("vector does not name highest live source");

	property p_vector_idle;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		none_live |=> (vector == VEC_NONE) && !o_irq;
	endproperty
	a_vector_idle: assert property (p_vector_idle)  // [RULE7]
		else $error("vector or request active with nothing live");

	property p_vector_undervolt;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		live_set[HI_UNDERVOLT_POS] |=> vector == VEC_UNDERVOLT;
	endproperty
	a_vector_undervolt: assert property (p_vector_undervolt)  // [RULE8]
		else $error("undervoltage did not take priority code 1");

	property p_vector_chan;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(live_set[HI_CHAN0_POS+1] && (live_set[HI_CHAN0_POS:0] == '0))
			|=> vector == VEC_CHAN1;
	endproperty
	a_vector_chan: assert property (p_vector_chan)  // [RULE9]
		else $error("timer channel 1 code wrong");

	property p_vector_serial_tx;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(live_set[HIGH_W+LO_SER_TX_POS] && (live_set[HIGH_W:0] == '0))
			|=> vector == VEC_SER_TX;
	endproperty
	a_vector_serial_tx: assert property (p_vector_serial_tx)  // [RULE10]
		else $error("serial transmit code wrong");

	property p_vector_cal;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(live_set == (SRC_N'(1) << (HIGH_W + LO_CAL_POS)))
			|=> vector == VEC_CALIBRATION;
	endproperty
	a_vector_cal: assert property (p_vector_cal)  // [RULE11]
		else $error("calibration request code wrong");

	sequence s_mask_uv_write;
		i_bus.wr && sel_mask_high && i_bus.wdata[HI_UNDERVOLT_POS];
	endsequence
	property p_mask_high_blocks;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		s_mask_uv_write ##1 !i_bus.wr |=> vector != VEC_UNDERVOLT;
	endproperty
	a_mask_high_blocks: assert property (p_mask_high_blocks)  // [RULE12]
		else $error("masked undervoltage still reported");

	property p_mask_low_blocks;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		mask_low[LO_CAL_POS] |=> vector != VEC_CALIBRATION;
	endproperty
	a_mask_low_blocks: assert property (p_mask_low_blocks)  // [RULE13]
		else $error("masked calibration request still reported");

	property p_nonblock_alias;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus.rd && page_nonbl && (offset == OFS_VECTOR))
			|=> o_rdata == {4'h0, $past(vector)};
	endproperty
	a_nonblock_alias: assert property (p_nonblock_alias)  // [RULE14]
		else $error("non-blocking page does not alias vector");

	property p_irq_live;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!none_live |=> o_irq;
	endproperty
	a_irq_live: assert property (p_irq_live)  // [RULE17]
		else $error("request missing with a live source");

	property p_rd_valid;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		1'b1 |=> o_rd_valid == $past(i_bus.rd);
	endproperty
	a_rd_valid: assert property (p_rd_valid)  // [RULE14]
		else $error("read valid does not follow the read strobe");

	property p_vector_high_temp;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(live_set[HI_HIGH_TEMP_POS] && !live_set[HI_UNDERVOLT_POS])
			|=> vector == VEC_HIGH_TEMP;
	endproperty
	a_vector_high_temp: assert property (p_vector_high_temp)  // [RULE8]
		else $error("high temperature did not take code 2");

	property p_vector_overflow;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(live_set[HI_OVERFLOW_POS] && (live_set[HI_OVERFLOW_POS-1:0] == '0))
			|=> vector == VEC_OVERFLOW;
	endproperty
	a_vector_overflow: assert property (p_vector_overflow)  // [RULE10]
		else $error("timer overflow code wrong");

	property p_vector_meas;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(live_set[HIGH_W+LO_MEAS_POS] && (live_set[HIGH_W+LO_MEAS_POS-1:0] == '0))
			|=> vector == VEC_MEAS;
	endproperty
	a_vector_meas: assert property (p_vector_meas)  // [RULE11]
		else $error("measurement complete code wrong");

	property p_status_overflow;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_src.timer_overflow_flag |=> status_high[HI_OVERFLOW_POS];
	endproperty
	a_status_overflow: assert property (p_status_overflow)  // [RULE15]
		else $error("timer overflow not shown in high status bit 7");

	property p_mask_wr_high;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		wr_mask_high |=> mask_high == $past(i_bus.wdata);
	endproperty
	a_mask_wr_high: assert property (p_mask_wr_high)  // [RULE12]
		else $error("high mask write did not land");

	property p_mask_wr_low;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		wr_mask_low |=> mask_low == $past(wr_data_low);
	endproperty
	a_mask_wr_low: assert property (p_mask_wr_low)  // [RULE13]
		else $error("low mask write did not land");

endmodule

/* core/aip_pkg.sv */
// Package for the analog die interrupt prioritizer: register map, field
// positions, reset values, vector codes and the structs carried on ports.
// Assumes one core clock domain and a byte-wide register port from the core.
package aip_pkg;

	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned HIGH_W = 8;
	localparam int unsigned LOW_W  = 6;
	localparam int unsigned SRC_N  = 14;

	// Page of the global address space: blocking and non-blocking views
	localparam logic [7:0] BASE_BLOCKING_PAGE = 8'h02;
	localparam logic [7:0] BASE_NONBLOCK_PAGE = 8'h03;

	localparam logic [7:0] OFS_STATUS_HIGH = 8'h08;
	localparam logic [7:0] OFS_STATUS_LOW  = 8'h09;
	localparam logic [7:0] OFS_VECTOR      = 8'h0A;
	localparam logic [7:0] OFS_RESERVED    = 8'h0B;
	localparam logic [7:0] OFS_MASK_HIGH   = 8'h0C;
	localparam logic [7:0] OFS_MASK_LOW    = 8'h0D;

	localparam logic [HIGH_W-1:0] MASK_HIGH_RST = 8'h00;
	localparam logic [LOW_W-1:0]  MASK_LOW_RST  = 6'h00;

	// High register field positions (pending status and mask share them)
	localparam int HI_UNDERVOLT_POS = 0;
	localparam int HI_HIGH_TEMP_POS = 1;
	localparam int HI_LIN_OT_POS    = 2;
	localparam int HI_CHAN0_POS     = 3;
	localparam int HI_OVERFLOW_POS  = 7;
	// Low register field positions
	localparam int LO_SER_ERR_POS   = 0;
	localparam int LO_SER_TX_POS    = 1;
	localparam int LO_SER_RX_POS    = 2;
	localparam int LO_MEAS_POS      = 3;
	localparam int LO_LIFETIME_POS  = 4;
	localparam int LO_CAL_POS       = 5;

	typedef enum logic [3:0] {
		VEC_NONE        = 4'h0,  // [RULE7]
		VEC_UNDERVOLT   = 4'h1,  // [RULE8]
		VEC_HIGH_TEMP   = 4'h2,
		VEC_LIN_OT      = 4'h3,
		VEC_CHAN0       = 4'h4,  // [RULE9]
		VEC_CHAN1       = 4'h5,
		VEC_CHAN2       = 4'h6,
		VEC_CHAN3       = 4'h7,
		VEC_OVERFLOW    = 4'h8,  // [RULE10]
		VEC_SER_ERR     = 4'h9,
		VEC_SER_TX      = 4'hA,
		VEC_SER_RX      = 4'hB,
		VEC_MEAS        = 4'hC,  // [RULE11]
		VEC_LIFETIME    = 4'hD,
		VEC_CALIBRATION = 4'hE
	} aip_vector_t;

	typedef struct packed {
		logic       calibration_request_flag;
		logic       lifetime_counter_flag;
		logic       current_done;
		logic       voltage_done;
		logic       serial_receive_flag;
		logic       serial_transmit_flag;
		logic       serial_error_flag;
		logic       timer_overflow_flag;
		logic [3:0] timer_chan_flag;
		logic       lin_overtemp_flag;
		logic       high_temp_flag;
		logic       undervoltage_flag;
	} aip_src_t;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} aip_bus_req_t;

	function automatic logic [HIGH_W-1:0] aip_pack_high(input aip_src_t s);
		logic [HIGH_W-1:0] v;
		v = '0;
		v[HI_UNDERVOLT_POS] = s.undervoltage_flag;
		v[HI_HIGH_TEMP_POS] = s.high_temp_flag;
		v[HI_LIN_OT_POS]    = s.lin_overtemp_flag;
		v[HI_CHAN0_POS +: 4] = s.timer_chan_flag;
		v[HI_OVERFLOW_POS]  = s.timer_overflow_flag;
		return v;
	endfunction

	function automatic logic [LOW_W-1:0] aip_pack_low(input aip_src_t s);
		logic [LOW_W-1:0] v;
		v = '0;
		v[LO_SER_ERR_POS]  = s.serial_error_flag;
		v[LO_SER_TX_POS]   = s.serial_transmit_flag;
		v[LO_SER_RX_POS]   = s.serial_receive_flag;
		v[LO_MEAS_POS]     = s.current_done | s.voltage_done;
		v[LO_LIFETIME_POS] = s.lifetime_counter_flag;
		v[LO_CAL_POS]      = s.calibration_request_flag;
		return v;
	endfunction

	// Bit i of the priority-ordered set maps to code i+1; lowest index wins
	function automatic aip_vector_t aip_first_code(input logic [SRC_N-1:0] pend);
		aip_vector_t c;
		c = VEC_NONE;
		for (int i = SRC_N - 1; i >= 0; i--)
		begin
			if (pend[i])
				c = aip_vector_t'(4'(i + 1));
		end
		return c;
	endfunction

endpackage

/* core/aip_mask_regs.sv */
// Two source mask registers, written by strobe from the register port.
// Assumes the caller decodes the address and raises one strobe per write.
`timescale 1ns/1ps
module aip_mask_regs
	import aip_pkg::*;
#(
	parameter int unsigned HW = HIGH_W,
	parameter int unsigned LW = LOW_W
)(
	input  wire logic          i_core_clk,   // Core clock
	input  wire logic          i_rst_n,      // Async reset, active low
	input  wire logic          i_wr_high,    // Write strobe, high mask
	input  wire logic          i_wr_low,     // Write strobe, low mask
	input  wire logic [HW-1:0] i_wdata,      // Write data
	output logic      [HW-1:0] o_mask_high,  // High mask, 1 disables
	output logic      [LW-1:0] o_mask_low    // Low mask, 1 disables
);

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_mask_high <= MASK_HIGH_RST;  // [RULE18]
			o_mask_low  <= MASK_LOW_RST;   // [RULE18]
		end
		else
		begin
			if (i_wr_high)
				o_mask_high <= i_wdata;            // [RULE12]
			if (i_wr_low)
				o_mask_low <= i_wdata[LW-1:0];     // [RULE13]
		end
	end

endmodule

/* core/aip_prio_enc.sv */
// Masked priority encoder that holds the vector code in a register.
// Assumes pending and mask sets are ordered by priority, bit 0 highest.
`timescale 1ns/1ps
module aip_prio_enc
	import aip_pkg::*;
#(
	parameter int unsigned N = SRC_N
)(
	input  wire logic        i_core_clk,  // Core clock
	input  wire logic        i_rst_n,     // Async reset, active low
	input  wire logic [N-1:0] i_pending,  // Pending set, priority order
	input  wire logic [N-1:0] i_mask,     // Mask set, 1 disables
	output aip_pkg::aip_vector_t o_vector, // Registered vector code
	output logic             o_irq        // Request to the core
);

	wire [N-1:0] live = i_pending & ~i_mask;  // [RULE17]
	aip_vector_t next_vector;

	assign next_vector = aip_first_code(live);  // [RULE6]

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_vector <= VEC_NONE;
		else
			o_vector <= next_vector;
	end

	assign o_irq = (o_vector != VEC_NONE);  // [RULE17]

endmodule

/* verification/aip_core_model.sv */
// Model of the microcontroller core that reads and writes the interrupt registers.
// Assumes one clock; the core changes its request only at the falling edge.
`timescale 1ns/1ps
module aip_core_model
	import aip_pkg::*;
(
	input  wire logic                     i_core_clk,  // Core clock
	input  wire logic [aip_pkg::DATA_W-1:0] i_rdata,   // Read data
	input  wire logic                     i_rd_valid,  // Read data valid
	output aip_pkg::aip_bus_req_t         o_bus        // Register request
);
	initial
	begin
		o_bus = '0;
	end

	// Released lines flip so a stale address never passes for a live one
	task automatic release_bus();
		o_bus.rd = 1'b0;
		o_bus.wr = 1'b0;
		o_bus.addr = ~o_bus.addr;
		o_bus.wdata = ~o_bus.wdata;
	endtask

	task automatic write_reg(input logic [15:0] addr, input logic [7:0] data);
		@(negedge i_core_clk);
		o_bus.wr = 1'b1;
		o_bus.addr = addr;
		o_bus.wdata = data;
		@(negedge i_core_clk);
		release_bus();
	endtask

	// Answer comes one edge after the read is taken
	task automatic read_reg(input logic [15:0] addr, output logic [7:0] data,
		output logic valid);
		@(negedge i_core_clk);
		o_bus.rd = 1'b1;
		o_bus.addr = addr;
		@(negedge i_core_clk);
		data = i_rdata;
		valid = i_rd_valid;
		release_bus();
	endtask
endmodule

/* verification/test_aip_top.sv */
// Self-checking bench for the interrupt prioritizer, driven through the core model.
// Assumes source flags are levels and the masks start at zero after reset.
`timescale 1ns/1ps
module test_aip_top;
	import aip_pkg::*;
	logic         i_core_clk;
	logic         i_rst_n;
	aip_src_t     src;
	aip_bus_req_t bus;
	logic [7:0]   rdata;
	logic         rd_valid;
	logic         irq;
	int           errors;
	int           total_checks;

	aip_top u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_src(src), .i_bus(bus),
		.o_rdata(rdata), .o_rd_valid(rd_valid), .o_irq(irq));
	aip_core_model u_core (.i_core_clk(i_core_clk), .i_rdata(rdata),
		.i_rd_valid(rd_valid), .o_bus(bus));

	initial
	begin
		i_core_clk = 1'b0;
	end
	always #20 i_core_clk = ~i_core_clk;

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp, input string name);
		logic [7:0] d;
		logic       v;
		u_core.read_reg(addr, d, v);
		chk(name, exp, d);
		chk({name, "_valid"}, 8'h01, {7'h00, v});
	endtask

	// Pending set in priority order, bit 0 highest; wait until the vector settles
	task automatic set_pend(input logic [13:0] p);
		aip_src_t s;
		s = '0;
		s.undervoltage_flag = p[0];
		s.high_temp_flag = p[1];
		s.lin_overtemp_flag = p[2];
		s.timer_chan_flag = p[6:3];
		s.timer_overflow_flag = p[7];
		s.serial_error_flag = p[8];
		s.serial_transmit_flag = p[9];
		s.serial_receive_flag = p[10];
		s.current_done = p[11];
		s.lifetime_counter_flag = p[12];
		s.calibration_request_flag = p[13];
		@(negedge i_core_clk);
		src = s;
		repeat (2) @(negedge i_core_clk);
	endtask

	task automatic t_reset();
		rd_chk(16'h020C, 8'h00, "mask_high");
		rd_chk(16'h020D, 8'h00, "mask_low");
		rd_chk(16'h020A, 8'h00, "vector");
		chk("irq", 8'h00, {7'h00, irq});
	endtask

	task automatic t_status();
		logic [13:0] e;
		for (int i = 0; i < 14; i++)
		begin
			e = 14'h0001 << i;
			set_pend(e);
			rd_chk(16'h0208, e[7:0], "status_high");
			rd_chk(16'h0309, {2'b00, e[13:8]}, "status_low");
		end
		set_pend(14'h0000);
		@(negedge i_core_clk);
		src.voltage_done = 1'b1;
		repeat (2) @(negedge i_core_clk);
		rd_chk(16'h0209, 8'h08, "status_low_volt");
		rd_chk(16'h020A, 8'h0C, "vector_volt");
	endtask

	task automatic t_prio();
		for (int i = 0; i < 14; i++)
		begin
			set_pend(14'h3FFF << i);
			rd_chk(16'h020A, 8'(i + 1), "vector");
			chk("irq", 8'h01, {7'h00, irq});
		end
		set_pend(14'h0000);
		rd_chk(16'h030A, 8'h00, "vector_idle");
		chk("irq_idle", 8'h00, {7'h00, irq});
	endtask

	// Mask the top k priorities one more at a time; the next one must win
	task automatic t_mask();
		logic [14:0] m;
		set_pend(14'h3FFF);
		for (int k = 1; k <= 14; k++)
		begin
			m = (15'h0001 << k) - 15'h0001;
			u_core.write_reg(16'h030C, m[7:0]);
			u_core.write_reg(16'h030D, {2'b00, m[13:8]});
			repeat (2) @(negedge i_core_clk);
			rd_chk(16'h020C, m[7:0], "mask_high");
			rd_chk(16'h020D, {2'b00, m[13:8]}, "mask_low");
			rd_chk(16'h020A, (k < 14) ? 8'(k + 1) : 8'h00, "vector_masked");
			chk("irq_masked", (k < 14) ? 8'h01 : 8'h00, {7'h00, irq});
		end
		rd_chk(16'h0209, 8'h3F, "status_masked");
		u_core.write_reg(16'h020C, 8'h00);
		u_core.write_reg(16'h020D, 8'h00);
	endtask

	task automatic t_readonly();
		set_pend(14'h0001);
		u_core.write_reg(16'h0209, 8'hFF);
		u_core.write_reg(16'h020A, 8'hFF);
		u_core.write_reg(16'h010C, 8'hFF);
		repeat (2) @(negedge i_core_clk);
		rd_chk(16'h0209, 8'h00, "status_low_ro");
		rd_chk(16'h020A, 8'h01, "vector_ro");
		rd_chk(16'h020C, 8'h00, "mask_other_page");
		rd_chk(16'h020B, 8'h00, "reserved");
		rd_chk(16'h040A, 8'h00, "unmapped_page");
	endtask

	// A reset in mid-run must clear masks the core has set
	task automatic t_rst_mid();
		u_core.write_reg(16'h020C, 8'hFF);
		u_core.write_reg(16'h020D, 8'h3F);
		rd_chk(16'h020C, 8'hFF, "mask_high_set");
		@(negedge i_core_clk);
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_core_clk);
		i_rst_n = 1'b1;
		rd_chk(16'h020C, 8'h00, "mask_high_rst");
		rd_chk(16'h020D, 8'h00, "mask_low_rst");
		rd_chk(16'h020A, 8'h01, "vector_rst");
	endtask

	initial
	begin
		errors = 0;
		total_checks = 0;
		src = '0;
		i_rst_n = 1'b0;
		repeat (5) @(negedge i_core_clk);
		i_rst_n = 1'b1;
		t_reset();
		t_status();
		t_prio();
		t_mask();
		t_readonly();
		t_rst_mid();
		close_out();
	end

	// Whole run needs well under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge i_core_clk);
		errors++;
		$display("[ERR] watchdog expected done seen hang");
		close_out();
	end
endmodule
